// *** inc/crf_consts.svh ***
// Purpose: Constants of the core register file: bus offsets, slots, resets
// Assumes: Included by bare name after the package
// Notes: Bus offsets are word indexes; byte address is four times the index
`ifndef CRF_CONSTS_SVH
`define CRF_CONSTS_SVH
`define CRF_AV_BANK1 5'h08
`define CRF_AV_BANK_END 5'h10
`define CRF_AV_VTB 5'h10
`define CRF_AV_PC 5'h11
`define CRF_AV_USP 5'h12
`define CRF_AV_ISP 5'h13
`define CRF_AV_SB 5'h14
`define CRF_AV_FLG 5'h15
`define CRF_SLOT_D0 3'h0
`define CRF_SLOT_D1 3'h1
`define CRF_SLOT_D2 3'h2
`define CRF_SLOT_D3 3'h3
`define CRF_SLOT_A0 3'h4
`define CRF_SLOT_A1 3'h5
`define CRF_SLOT_FB 3'h6
`define CRF_SLOT_NONE 3'h7
`define CRF_BANK_SLOTS 7
`define CRF_REG_COUNT 13
`define CRF_FLG_W 11
`define CRF_RST16 16'h0000
`define CRF_RST_FLG 11'h000
`define CRF_RST_PC 20'h00000
`define CRF_RST_VTB 20'h00000
`define CRF_TRAP_LIMIT 6'h20
`endif

// *** inc/crf_pkg.sv ***
// Purpose: Types shared by the core register file and its users
// Assumes: Nothing
// Notes: Flag layout from bit 10 down to bit 0 follows the struct order
package crf_pkg;
  typedef enum logic [3:0] {
    CRF_DATA_ZERO, CRF_DATA_ONE, CRF_DATA_TWO, CRF_DATA_THREE,
    CRF_ADDR_ZERO, CRF_ADDR_ONE, CRF_FRAME_BASE, CRF_VECTOR_BASE,
    CRF_PROG_CNT, CRF_STACK_PTR, CRF_STATIC_BASE, CRF_FLAGS,
    CRF_USER_SP, CRF_INT_SP
  } crf_reg_e;
  typedef enum logic [1:0] {CRF_SZ_LOW, CRF_SZ_HIGH, CRF_SZ_WORD, CRF_SZ_LONG} crf_size_e;
  typedef struct packed {
    logic [2:0] proc_priority_level;
    logic stk_sel;
    logic int_en;
    logic ovf;
    logic bank_sel;
    logic sign;
    logic zero;
    logic dbg;
    logic carry;
  } crf_flag_s;
  typedef struct packed {
    crf_reg_e sel;
    crf_size_e size;
    logic [31:0] data;
  } crf_wr_s;
  typedef struct packed {
    logic c_we;
    logic c;
    logic zs_we;
    logic byte_op;
    logic [15:0] res;
    logic ov_we;
    logic ov;
  } crf_alu_s;
endpackage : crf_pkg

// *** src/crf_cpu_regs.sv ***
// Purpose: Programmer-visible register set and flag register of a 16-bit core
// Assumes: Core decoder, ALU and interrupt logic share ref_clk_i and reset
// Notes: Avalon-MM slave gives debug access; its writes win over core writes only for the banked words and the flag register
// Summary of operation
// - Thirteen visible registers, banked ones counted once
// - Data, address, frame base duplicated per bank
// - Data words 16-bit; first two byte-splittable
// - Third over first, fourth over second: 32-bit
// - Address pair 16-bit each, forms 32-bit
// - Frame base 16-bit, frame-relative addressing base
// - Vector table base 20-bit table start
// - Program counter 20-bit, next instruction address
// - Two 16-bit stack pointers, flag selects
// - Hardware ack or trap 0-31 clears select
// - Static base 16-bit addressing base
// - Flag register 11-bit processor state
// - Carry captures ALU carry, borrow, shift-out
// - Zero flag set on zero result
// - Sign flag set on negative result
// - Bank select flag picks register bank
// - Overflow flag set on overflow
// - Interrupt enable flag gates maskable requests
// - Any interrupt acknowledge clears enable flag
// - Priority field 3-bit; request must exceed
// - Reserved flag bits undefined; write zero
`timescale 1ns/100ps
`default_nettype none
`include "crf_consts.svh"
module crf_cpu_regs
  import crf_pkg::*;
#(
  parameter int PC_W = 20,
  parameter int VTB_W = 20
)
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic wr_en_i,
  input wire crf_wr_s wr_req_i,
  input wire crf_reg_e rd_sel_i,
  input wire crf_size_e rd_size_i,
  output logic [31:0] rd_data_o,
  input wire logic pc_we_i,
  input wire logic [PC_W-1:0] pc_i,
  output logic [PC_W-1:0] pc_o,
  input wire crf_alu_s alu_i,
  input wire logic irq_req_i,
  input wire logic irq_nmi_i,
  input wire logic [2:0] irq_prio_i,
  output logic irq_accept_o,
  input wire logic irq_ack_i,
  input wire logic [2:0] irq_ack_ipl_i,
  input wire logic trap_i,
  input wire logic [5:0] trap_num_i,
  output var crf_flag_s flag_o,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);

  if (PC_W < 17 || PC_W > 32)
  begin : g_pc_chk
    $error("PC_W must lie in 17..32");
  end
  if (VTB_W < 17 || VTB_W > 32)
  begin : g_vtb_chk
    $error("VTB_W must lie in 17..32");
  end

  // Two banks of seven words, one copy of each banked register
  logic [15:0] bank_r [0:1][0:`CRF_BANK_SLOTS-1];
  logic [15:0] bank_nxt [0:1][0:`CRF_BANK_SLOTS-1];
  logic [VTB_W-1:0] vtb_r;
  logic [PC_W-1:0] pc_r;
  logic [15:0] usp_r;
  logic [15:0] isp_r;
  logic [15:0] sb_r;
  crf_flag_s flag_r;
  crf_flag_s flag_nxt;
  logic [31:0] rd_nxt;
  logic [31:0] avs_rd_nxt;
  logic wait_r;
  logic bus_wr;
  logic bsel;
  logic [2:0] core_slot;
  logic [15:0] cur_d0;

  function automatic logic [2:0] crf_slot(input crf_reg_e sel);
    if (sel <= CRF_FRAME_BASE)
      return sel[2:0];
    return `CRF_SLOT_NONE;
  endfunction : crf_slot

  // Upper partner of a 32-bit pair, none for the others
  function automatic logic [2:0] crf_pair(input logic [2:0] slot);
    case (slot)
      `CRF_SLOT_D0: return `CRF_SLOT_D2;
      `CRF_SLOT_D1: return `CRF_SLOT_D3;
      `CRF_SLOT_A0: return `CRF_SLOT_A1;
      default: return `CRF_SLOT_NONE;
    endcase
  endfunction : crf_pair

  // Byte lanes only on the first two data words
  function automatic logic [15:0] crf_merge(input logic [15:0] old, input logic [15:0] d,
                                            input crf_size_e size, input logic [2:0] slot);
    if (slot <= `CRF_SLOT_D1 && size == CRF_SZ_LOW)
      return {old[15:8], d[7:0]};
    if (slot <= `CRF_SLOT_D1 && size == CRF_SZ_HIGH)
      return {d[7:0], old[7:0]};
    return d;
  endfunction : crf_merge

  assign bsel = flag_r.bank_sel;
  assign core_slot = crf_slot(wr_req_i.sel);
  assign bus_wr = avs_write_i && !wait_r;
  assign cur_d0 = bank_r[bsel][`CRF_SLOT_D0];

  // Banked storage; bus writes land after core writes
  always_comb
  begin
    bank_nxt = bank_r;
    if (wr_en_i && core_slot != `CRF_SLOT_NONE)
    begin
      bank_nxt[bsel][core_slot] = crf_merge(bank_r[bsel][core_slot], wr_req_i.data[15:0],
                                            wr_req_i.size, core_slot);
      if (wr_req_i.size == CRF_SZ_LONG && crf_pair(core_slot) != `CRF_SLOT_NONE)
        bank_nxt[bsel][crf_pair(core_slot)] = wr_req_i.data[31:16];
    end
    if (bus_wr && avs_address_i < `CRF_AV_BANK_END && avs_address_i[2:0] != `CRF_SLOT_NONE)
      bank_nxt[avs_address_i[3]][avs_address_i[2:0]] = avs_writedata_i[15:0];
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int b = 0; b < 2; b++)
        for (int s = 0; s < `CRF_BANK_SLOTS; s++)
          bank_r[b][s] <= `CRF_RST16;
    end
    else
      bank_r <= bank_nxt;
  end

  // Vector base, static base and stack pointers
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      vtb_r <= VTB_W'(`CRF_RST_VTB);
      sb_r <= `CRF_RST16;
      usp_r <= `CRF_RST16;
      isp_r <= `CRF_RST16;
    end
    else
    begin
      if (wr_en_i && wr_req_i.sel == CRF_VECTOR_BASE)
        vtb_r <= wr_req_i.data[VTB_W-1:0];
      else if (bus_wr && avs_address_i == `CRF_AV_VTB)
        vtb_r <= avs_writedata_i[VTB_W-1:0];
      if (wr_en_i && wr_req_i.sel == CRF_STATIC_BASE)
        sb_r <= wr_req_i.data[15:0];
      else if (bus_wr && avs_address_i == `CRF_AV_SB)
        sb_r <= avs_writedata_i[15:0];
      if (wr_en_i && (wr_req_i.sel == CRF_USER_SP || (wr_req_i.sel == CRF_STACK_PTR && flag_r.stk_sel)))
        usp_r <= wr_req_i.data[15:0];
      else if (bus_wr && avs_address_i == `CRF_AV_USP)
        usp_r <= avs_writedata_i[15:0];
      if (wr_en_i && (wr_req_i.sel == CRF_INT_SP || (wr_req_i.sel == CRF_STACK_PTR && !flag_r.stk_sel)))
        isp_r <= wr_req_i.data[15:0];
      else if (bus_wr && avs_address_i == `CRF_AV_ISP)
        isp_r <= avs_writedata_i[15:0];
    end
  end

  // Program counter; the dedicated load port wins over a general write
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pc_r <= PC_W'(`CRF_RST_PC);
    else if (pc_we_i)
      pc_r <= pc_i;
    else if (wr_en_i && wr_req_i.sel == CRF_PROG_CNT)
      pc_r <= wr_req_i.data[PC_W-1:0];
    else if (bus_wr && avs_address_i == `CRF_AV_PC)
      pc_r <= avs_writedata_i[PC_W-1:0];
  end

  // Flags: writes first, then ALU results, then acknowledge effects
  always_comb
  begin
    flag_nxt = flag_r;
    if (wr_en_i && wr_req_i.sel == CRF_FLAGS)
      flag_nxt = crf_flag_s'(wr_req_i.data[`CRF_FLG_W-1:0]);
    if (bus_wr && avs_address_i == `CRF_AV_FLG)
      flag_nxt = crf_flag_s'(avs_writedata_i[`CRF_FLG_W-1:0]);
    if (alu_i.c_we)
      flag_nxt.carry = alu_i.c;
    if (alu_i.zs_we)
    begin
      flag_nxt.zero = alu_i.byte_op ? (alu_i.res[7:0] == 8'h00) : (alu_i.res == 16'h0000);
      flag_nxt.sign = alu_i.byte_op ? alu_i.res[7] : alu_i.res[15];
    end
    if (alu_i.ov_we)
      flag_nxt.ovf = alu_i.ov;
    if (trap_i)
    begin
      flag_nxt.int_en = 1'b0;
      if (trap_num_i < `CRF_TRAP_LIMIT)
        flag_nxt.stk_sel = 1'b0;
    end
    if (irq_ack_i)
    begin
      flag_nxt.int_en = 1'b0;
      flag_nxt.stk_sel = 1'b0;
      flag_nxt.proc_priority_level = irq_ack_ipl_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      flag_r <= crf_flag_s'(`CRF_RST_FLG);
    else
      flag_r <= flag_nxt;
  end

  // Non-maskable requests bypass enable and level
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      irq_accept_o <= 1'b0;
    else
      irq_accept_o <= irq_req_i && (irq_nmi_i || (flag_r.int_en && irq_prio_i > flag_r.proc_priority_level));
  end

  // Core read port, registered so every output leaves a flop
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    case (rd_sel_i)
      CRF_DATA_ZERO, CRF_DATA_ONE:
      begin
        case (rd_size_i)
          CRF_SZ_LOW: rd_nxt = {24'h00_0000, bank_r[bsel][crf_slot(rd_sel_i)][7:0]};
          CRF_SZ_HIGH: rd_nxt = {24'h00_0000, bank_r[bsel][crf_slot(rd_sel_i)][15:8]};
          CRF_SZ_LONG: rd_nxt = {bank_r[bsel][crf_pair(crf_slot(rd_sel_i))],
                                 bank_r[bsel][crf_slot(rd_sel_i)]};
          default: rd_nxt = {16'h0000, bank_r[bsel][crf_slot(rd_sel_i)]};
        endcase
      end
      CRF_ADDR_ZERO:
      begin
        if (rd_size_i == CRF_SZ_LONG)
          rd_nxt = {bank_r[bsel][`CRF_SLOT_A1], bank_r[bsel][`CRF_SLOT_A0]};
        else
          rd_nxt = {16'h0000, bank_r[bsel][`CRF_SLOT_A0]};
      end
      CRF_DATA_TWO, CRF_DATA_THREE, CRF_ADDR_ONE, CRF_FRAME_BASE:
        rd_nxt = {16'h0000, bank_r[bsel][crf_slot(rd_sel_i)]};
      CRF_VECTOR_BASE: rd_nxt = 32'(vtb_r);
      CRF_PROG_CNT: rd_nxt = 32'(pc_r);
      CRF_STACK_PTR: rd_nxt = {16'h0000, flag_r.stk_sel ? usp_r : isp_r};
      CRF_STATIC_BASE: rd_nxt = {16'h0000, sb_r};
      CRF_FLAGS: rd_nxt = 32'(flag_r);
      CRF_USER_SP: rd_nxt = {16'h0000, usp_r};
      CRF_INT_SP: rd_nxt = {16'h0000, isp_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rd_data_o <= 32'h0000_0000;
    else
      rd_data_o <= rd_nxt;
  end

  // Debug map; all thirteen registers plus the idle bank are visible
  always_comb
  begin
    avs_rd_nxt = 32'h0000_0000;
    if (avs_address_i < `CRF_AV_BANK_END)
    begin
      if (avs_address_i[2:0] != `CRF_SLOT_NONE)
        avs_rd_nxt = {16'h0000, bank_r[avs_address_i[3]][avs_address_i[2:0]]};
    end
    else
    begin
      case (avs_address_i)
        `CRF_AV_VTB: avs_rd_nxt = 32'(vtb_r);
        `CRF_AV_PC: avs_rd_nxt = 32'(pc_r);
        `CRF_AV_USP: avs_rd_nxt = {16'h0000, usp_r};
        `CRF_AV_ISP: avs_rd_nxt = {16'h0000, isp_r};
        `CRF_AV_SB: avs_rd_nxt = {16'h0000, sb_r};
        // Reserved bits above the flags read as zero
        `CRF_AV_FLG: avs_rd_nxt = 32'(flag_r);
        default: avs_rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  // One wait cycle per access keeps read data on a flop
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      wait_r <= 1'b1;
    else if (wait_r && (avs_read_i || avs_write_i))
      wait_r <= 1'b0;
    else
      wait_r <= 1'b1;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (wait_r && avs_read_i)
      avs_readdata_o <= avs_rd_nxt;
  end

  assign avs_waitrequest_o = wait_r;
  assign pc_o = pc_r;
  assign flag_o = flag_r;

  ack_ie_clr_a:
  assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (irq_ack_i || trap_i) |=> !flag_o.int_en)
  else $error("Interrupt enable not cleared after acknowledge");

  ack_stk_clr_a:
  assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (irq_ack_i || (trap_i && trap_num_i < `CRF_TRAP_LIMIT)) |=> !flag_o.stk_sel)
  else $error("Stack select not cleared after acknowledge or low trap");

  zero_flag_a:
  assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (alu_i.zs_we && !alu_i.byte_op) |=> (flag_o.zero == ($past(alu_i.res) == 16'h0000)))
  else $error("Zero flag does not match result");

  sign_flag_a:
  assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (alu_i.zs_we && !alu_i.byte_op) |=> (flag_o.sign == $past(alu_i.res[15])))
  else $error("Sign flag does not match result");

  carry_ovf_a:
  assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (alu_i.c_we && alu_i.ov_we) |=> (flag_o.carry == $past(alu_i.c) && flag_o.ovf == $past(alu_i.ov)))
  else $error("Carry or overflow flag not captured");

  mask_block_a:
  assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (irq_req_i && !irq_nmi_i && !flag_o.int_en) |=> !irq_accept_o)
  else $error("Maskable request accepted while disabled");

  prio_gate_a:
  assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (irq_accept_o && !$past(irq_nmi_i)) |-> ($past(irq_prio_i) > $past(flag_o.proc_priority_level)))
  else $error("Request accepted at or below processor level");

  bank_read_a:
  assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (rd_sel_i == CRF_DATA_ZERO && rd_size_i == CRF_SZ_WORD) |=> (rd_data_o == {16'h0000, $past(cur_d0)}))
  else $error("Data read not from selected bank");

  bus_wait_a:
  assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (avs_waitrequest_o && (avs_read_i || avs_write_i)) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
  else $error("Bus answer not given after one wait cycle");

endmodule : crf_cpu_regs
`default_nettype wire

// *** test/crf_ack_model.sv ***
// Purpose: Interrupt acknowledge side of the core, facing the register file
// Assumes: Accept output is registered and the request is held by the bench
// Notes: Acks an accept unless it acked the cycle before, so never on two cycles in a row
`timescale 1ns/100ps
`default_nettype none
module crf_ack_model
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic accept_i,
  input wire logic [2:0] prio_i,
  output logic ack_o,
  output logic [2:0] ack_ipl_o
);
  // Level is only meaningful with the pulse; otherwise keep it moving
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ack_o <= 1'b0;
      ack_ipl_o <= 3'h0;
    end
    else
    begin
      ack_o <= accept_i && !ack_o;
      ack_ipl_o <= (accept_i && !ack_o) ? prio_i : ~ack_ipl_o;
    end
  end
endmodule : crf_ack_model
`default_nettype wire

// *** test/tb_top.sv ***
// Purpose: Self-checking bench of the core register file
// Assumes: One clock; bus reads and core reads are scored in issue order
// Notes: Flag values are bit patterns of the package flag struct
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import crf_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr_en = 1'b0;
  logic pc_we = 1'b0;
  logic irq_req = 1'b0;
  logic irq_nmi = 1'b0;
  logic trap = 1'b0;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  crf_wr_s wr_req = '0;
  crf_reg_e rd_sel = CRF_DATA_ZERO;
  crf_size_e rd_size = CRF_SZ_WORD;
  crf_alu_s alu_v = '0;
  logic [19:0] pc_v = 20'h00000;
  logic [2:0] prio = 3'h0;
  logic [5:0] trap_num = 6'h00;
  logic [4:0] av_a = 5'h00;
  logic [31:0] av_wd = 32'h00000000;
  logic [31:0] rd_data, av_rdd;
  logic [19:0] pc_q;
  logic acc, av_wait, ack;
  logic [2:0] ack_ipl;
  crf_flag_s cpu_flag_reg;
  int fails = 0;
  int checked = 0;
  int seed = 32'h9287;
  logic [31:0] m [0:31];
  logic [31:0] eq [$];
  logic [1:0] st = 2'h0;
  logic [1:0] st_d = 2'h0;

  always #25 clk = ~clk;

  crf_cpu_regs DUT (.ref_clk_i(clk), .reset_n_i(rst_n), .wr_en_i(wr_en), .wr_req_i(wr_req),
    .rd_sel_i(rd_sel), .rd_size_i(rd_size), .rd_data_o(rd_data), .pc_we_i(pc_we), .pc_i(pc_v),
    .pc_o(pc_q), .alu_i(alu_v), .irq_req_i(irq_req), .irq_nmi_i(irq_nmi), .irq_prio_i(prio),
    .irq_accept_o(acc), .irq_ack_i(ack), .irq_ack_ipl_i(ack_ipl), .trap_i(trap),
    .trap_num_i(trap_num), .flag_o(cpu_flag_reg), .avs_address_i(av_a), .avs_read_i(av_rd),
    .avs_write_i(av_wr), .avs_writedata_i(av_wd), .avs_readdata_o(av_rdd),
    .avs_waitrequest_o(av_wait));

  crf_ack_model u_ack (.ref_clk_i(clk), .reset_n_i(rst_n), .accept_i(acc), .prio_i(prio),
    .ack_o(ack), .ack_ipl_o(ack_ipl));

  task close_out;
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Scoreboard: each result takes the oldest note
  always @(posedge clk)
  begin
    st_d <= st;
    if (av_rd && av_wait === 1'b0)
      check("avs_readdata", av_rdd, eq.pop_front());
    if (st_d == 2'h1)
      check("rd_data", rd_data, eq.pop_front());
    if (st_d == 2'h2)
      check("irq_accept", {31'h0, acc}, eq.pop_front());
  end

  function automatic logic [31:0] msk(input int a);
    if (a == 7 || a == 15 || a > 21)
      return 32'h0;
    if (a == 16 || a == 17)
      return 32'hFFFFF;
    if (a == 21)
      return 32'h7FF;
    return 32'hFFFF;
  endfunction : msk

  task avs(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    av_a <= a;
    av_wr <= w;
    av_rd <= !w;
    av_wd <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (av_wait !== 1'b0 && n < 20);
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    if (av_wait !== 1'b0)
    begin
      fails++;
      close_out();
    end
    if (w)
      m[a] = d & msk(a);
  endtask : avs

  task rd(input logic [4:0] a, input logic [31:0] e);
    eq.push_back(e);
    avs(1'b0, a, 32'h0);
  endtask : rd

  task crd(input crf_reg_e s, input crf_size_e z, input logic [31:0] e);
    eq.push_back(e);
    @(posedge clk);
    rd_sel <= s;
    rd_size <= z;
    st <= 2'h1;
    @(posedge clk);
    st <= 2'h0;
  endtask : crd

  // One-cycle core write strobe; the write lands at the edge that ends it
  task cwr(input crf_reg_e s, input crf_size_e z, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_req <= '{sel: s, size: z, data: d};
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : cwr

  task alu(input crf_alu_s v, input logic [31:0] e);
    @(posedge clk);
    alu_v <= v;
    @(posedge clk);
    alu_v <= '0;
    crd(CRF_FLAGS, CRF_SZ_WORD, e);
  endtask : alu

  // Hold the request long enough for the ack and its side effects to land
  task irq(input logic n, input logic [2:0] p, input logic e);
    eq.push_back({31'h0, e});
    @(posedge clk);
    irq_req <= 1'b1;
    irq_nmi <= n;
    prio <= p;
    st <= 2'h2;
    @(posedge clk);
    st <= 2'h0;
    repeat (3) @(posedge clk);
    irq_req <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : irq

  initial
  begin
    for (int i = 0; i < 32; i++)
      m[i] = 32'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(5'h15, 32'h0);
    for (int a = 0; a < 24; a++)
      if (a != 21)
        avs(1'b1, a[4:0], $random(seed));
    for (int a = 0; a < 24; a++)
      rd(a[4:0], m[a]);
    avs(1'b1, 5'h15, 32'h010);
    crd(CRF_DATA_ZERO, CRF_SZ_WORD, m[8]);
    crd(CRF_DATA_ZERO, CRF_SZ_LOW, m[8] & 32'hFF);
    crd(CRF_DATA_ONE, CRF_SZ_HIGH, m[9] >> 8);
    crd(CRF_DATA_ZERO, CRF_SZ_LONG, {m[10][15:0], m[8][15:0]});
    crd(CRF_DATA_ONE, CRF_SZ_LONG, {m[11][15:0], m[9][15:0]});
    crd(CRF_ADDR_ZERO, CRF_SZ_LONG, {m[13][15:0], m[12][15:0]});
    crd(CRF_FRAME_BASE, CRF_SZ_WORD, m[14]);
    crd(CRF_VECTOR_BASE, CRF_SZ_WORD, m[16]);
    crd(CRF_STATIC_BASE, CRF_SZ_WORD, m[20]);
    crd(CRF_STACK_PTR, CRF_SZ_WORD, m[19]);
    crd(CRF_FLAGS, CRF_SZ_WORD, 32'h010);
    avs(1'b1, 5'h15, 32'h090);
    crd(CRF_STACK_PTR, CRF_SZ_WORD, m[18]);
    avs(1'b1, 5'h15, 32'h000);
    crd(CRF_DATA_ZERO, CRF_SZ_WORD, m[0]);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_req <= '{sel: CRF_DATA_ONE, size: CRF_SZ_LONG, data: 32'hA5C31E2F};
    pc_we <= 1'b1;
    pc_v <= 20'h5A5A5;
    @(posedge clk);
    wr_en <= 1'b0;
    pc_we <= 1'b0;
    rd(5'h01, 32'h1E2F);
    rd(5'h03, 32'hA5C3);
    crd(CRF_PROG_CNT, CRF_SZ_WORD, 32'h5A5A5);
    check("pc_o", {12'h000, pc_q}, 32'h5A5A5);
    cwr(CRF_DATA_ZERO, CRF_SZ_HIGH, 32'h0000_00C3);
    crd(CRF_DATA_ZERO, CRF_SZ_WORD, {16'h0000, 8'hC3, m[0][7:0]});
    cwr(CRF_USER_SP, CRF_SZ_WORD, 32'h0000_1234);
    cwr(CRF_INT_SP, CRF_SZ_WORD, 32'h0000_4321);
    crd(CRF_USER_SP, CRF_SZ_WORD, 32'h1234);
    crd(CRF_INT_SP, CRF_SZ_WORD, 32'h4321);
    cwr(CRF_STACK_PTR, CRF_SZ_WORD, 32'h0000_0BEE);
    rd(5'h13, 32'h0BEE);
    cwr(CRF_VECTOR_BASE, CRF_SZ_WORD, 32'h000A_BCDE);
    rd(5'h10, 32'hABCDE);
    cwr(CRF_STATIC_BASE, CRF_SZ_WORD, 32'h0000_5A5A);
    rd(5'h14, 32'h5A5A);
    cwr(CRF_FLAGS, CRF_SZ_WORD, 32'h0000_0010);
    crd(CRF_DATA_TWO, CRF_SZ_WORD, m[10]);
    cwr(CRF_FLAGS, CRF_SZ_WORD, 32'h0000_0000);
    alu({4'b1110, 16'h0000, 2'b11}, 32'h025);
    alu({4'b1010, 16'h8000, 2'b10}, 32'h008);
    alu({4'b0011, 16'h7F80, 2'b00}, 32'h008);
    alu({4'b0011, 16'h8100, 2'b00}, 32'h004);
    avs(1'b1, 5'h15, 32'h2C0);
    irq(1'b0, 3'h3, 1'b1);
    crd(CRF_FLAGS, CRF_SZ_WORD, 32'h300);
    avs(1'b1, 5'h15, 32'h340);
    irq(1'b0, 3'h3, 1'b0);
    avs(1'b1, 5'h15, 32'h340);
    irq(1'b0, 3'h4, 1'b1);
    avs(1'b1, 5'h15, 32'h000);
    irq(1'b0, 3'h7, 1'b0);
    irq(1'b1, 3'h0, 1'b1);
    for (int i = 0; i < 2; i++)
    begin
      avs(1'b1, 5'h15, 32'h0C0);
      @(posedge clk);
      trap <= 1'b1;
      trap_num <= (i == 0) ? 6'h1F : 6'h20;
      @(posedge clk);
      trap <= 1'b0;
      crd(CRF_FLAGS, CRF_SZ_WORD, (i == 0) ? 32'h000 : 32'h080);
      check("flag_o", {21'h0, cpu_flag_reg}, (i == 0) ? 32'h000 : 32'h080);
    end
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
